// File: pdr_pkg.sv
package pdr_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0]  PDR_ADDR_PAIR_DELAY_0 = 8'h00;
    localparam logic [7:0]  PDR_ADDR_PAIR_DELAY_1 = 8'h04;
    localparam logic [7:0]  PDR_ADDR_STATUS_COMM  = 8'h08;
    localparam logic [7:0]  PDR_ADDR_CONFIG_ZERO  = 8'h0C;
    localparam logic [7:0]  PDR_ADDR_CONFIG_ONE   = 8'h10;
    localparam logic [7:0]  PDR_ADDR_CHAN_ACTIVE  = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PDR_FLD_DELAY_LO       = 0;
    localparam int PDR_FLD_DELAY_HI       = 12;
    localparam int PDR_FLD_READY_FLAGS    = 0;
    localparam int PDR_FLD_LINK_MODE      = 8;
    localparam int PDR_FLD_OFFSET_EN      = 0;
    localparam int PDR_FLD_GAIN_EN        = 1;
    localparam int PDR_FLD_EXT_CLOCK      = 0;
    localparam int PDR_FLD_PRESCALE       = 1;
    localparam int PDR_FLD_OSR_SEL        = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [23:0] PDR_RST_PAIR_DELAY    = 24'h000000;
    localparam logic [7:0]  PDR_RST_READY_FLAGS   = 8'hFF;
    localparam logic        PDR_RST_LINK_MODE     = 1'b1;
    localparam logic        PDR_RST_EXT_CLOCK     = 1'b0;
    localparam logic [1:0]  PDR_RST_PRESCALE      = 2'h0;
    localparam logic [2:0]  PDR_RST_OSR_SEL       = 3'h7;
    localparam logic [7:0]  PDR_RST_CHAN_ACTIVE   = 8'hFF;

    // ------------------------------------------------------------------
    // Timing: one delay step is one decimated period (1 us by default)
    // ------------------------------------------------------------------
    localparam int PDR_STEP_NS        = 1000;
    localparam int PDR_CLK_PERIOD_NS  = 4;
    localparam int PDR_STEP_CYCLES    = PDR_STEP_NS / PDR_CLK_PERIOD_NS;
    localparam int PDR_OSR_MIN_LOG2   = 5;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        pwrite;
        logic [31:0] pwdata;
    } pdr_apb_req_t;

endpackage

// File: pdr_phase_ready.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - One delay code step equals one decimated clock period, 1 us by default.
// - Delay time scales with prescaler setting and master clock rate.
// - Even and odd ready pulses of a pair are apart by the pair code.
// - Conversion starts and ready pulses shifted by half the ratio from reset.
// - Odd channels ready at reference; even ones lead or lag by code.
// - Usable range is minus half ratio to half ratio minus one.
// - Any delay register write restarts all channels, even same value.
// - Sign bit position follows ratio, bit 11 at 4096 to bit 4 at 32.
// - At ratio 4096 code is two's complement, -2048 to +2047.
// - Link mode 0: ready pin carries channel 0 and channel 1 pulses.
// - Link mode 1 default: ready pin carries most lagging active channel only.
// - Linked mode latches all active channel results together at lagging ready.
// - Eight ready flags readable anytime; writes to them do nothing.
// - Flags reset to 1 and go 0 when channel output updates.
// - Reading status register returns all flags to 1.
// - Linked mode updates all flags with lagging channel; unlinked, per channel. Here only flags of active channels update.
// - External clock select 0 runs crystal; 1 bypasses and pulls pin low.
// - Two global bits enable offset and gain correction on all channels.
// - Two 24-bit delay registers each hold two 12-bit pair fields.
// - Positive code makes even channel lag odd; negative makes it lead.
// - All odd channels stay synchronous and ready at the same instant.
module pdr_phase_ready #(
    parameter int STEP_CYCLES = pdr_pkg::PDR_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Clock source control
    output logic             osc_enable_o,
    output logic             osc_bypass_o,
    output logic             osc_out_pin_o,
    output logic             osc_out_pin_oe_o,
    // Correction enables
    output logic             offset_corr_enable_o,
    output logic             gain_corr_enable_o,
    // Conversion timing
    output logic             decimated_modulator_clock_o,
    output logic [7:0]       chan_latch_o,
    output logic             ready_pin_n_o
);
    import pdr_pkg::*;

    // How the block fits together.
    //
    // The register file sits behind a zero-wait APB slave. Writes take effect at the access edge,
    // and read data is loaded during the setup cycle so that it is settled by the access edge.
    //
    // A prescaler divides the system clock into the decimated tick. One tick is one delay step,
    // so every timing figure of the block scales with the prescale setting and the step length.
    //
    // A phase counter counts ticks over one output-rate period of ratio ticks. Odd channels fire
    // at half the ratio. Each even channel fires at half the ratio plus the signed code of its pair.
    //
    // Any delay register write raises a one-cycle restart. The restart clears both counters, so
    // the first ready events after it come half a period later, just as they do after reset.
    //
    // In linked mode every active channel latches at the most lagging active event, and the ready
    // pin pulses once per period. In unlinked mode each channel latches at its own event, and the
    // ready pin shows only the events of channel 0 and channel 1.
    //
    // The ready flags follow the latch pulses. A status read sets them all back to 1, but a latch
    // in the same cycle still clears its flag; only a result latched in the read's setup cycle can be reported as stale.
    //
    // Limitations: the gain correction pipeline delay is not modelled, and channels that are not
    // active never latch and never clear their flags.

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [23:0] delay0_reg, delay0_next;
    logic [23:0] delay1_reg, delay1_next;
    logic        link_reg, link_next;
    logic        offen_reg, offen_next;
    logic        gainen_reg, gainen_next;
    logic        ext_reg, ext_next;
    logic [1:0]  pre_reg, pre_next;
    logic [2:0]  osr_reg, osr_next;
    logic [7:0]  active_reg, active_next;
    logic [7:0]  flags_reg, flags_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        restart_reg, restart_next;

    logic        acc_wr, acc_rd;
    logic [7:0]  upd;

    assign acc_wr = psel_i & penable_i & pwrite_i;
    assign acc_rd = psel_i & penable_i & ~pwrite_i;

    always_comb begin
        delay0_next  = delay0_reg;
        delay1_next  = delay1_reg;
        link_next    = link_reg;
        offen_next   = offen_reg;
        gainen_next  = gainen_reg;
        ext_next     = ext_reg;
        pre_next     = pre_reg;
        osr_next     = osr_reg;
        active_next  = active_reg;
        rdata_next   = rdata_reg;
        restart_next = 1'b0;
        flags_next   = flags_reg;
        if (acc_wr) begin
            unique case (paddr_i)
                PDR_ADDR_PAIR_DELAY_0: begin
                    delay0_next  = pwdata_i[23:0];
                    restart_next = 1'b1;
                end
                PDR_ADDR_PAIR_DELAY_1: begin
                    delay1_next  = pwdata_i[23:0];
                    restart_next = 1'b1;
                end
                PDR_ADDR_STATUS_COMM: begin
                    link_next = pwdata_i[PDR_FLD_LINK_MODE];  // ready flags not writable
                end
                PDR_ADDR_CONFIG_ZERO: begin
                    offen_next  = pwdata_i[PDR_FLD_OFFSET_EN];
                    gainen_next = pwdata_i[PDR_FLD_GAIN_EN];
                end
                PDR_ADDR_CONFIG_ONE: begin
                    ext_next = pwdata_i[PDR_FLD_EXT_CLOCK];
                    pre_next = pwdata_i[PDR_FLD_PRESCALE +: 2];
                    osr_next = pwdata_i[PDR_FLD_OSR_SEL +: 3];
                end
                PDR_ADDR_CHAN_ACTIVE: begin
                    active_next = pwdata_i[7:0];
                end
                default: ;
            endcase
        end
        if (psel_i & ~penable_i & ~pwrite_i) begin
            unique case (paddr_i)
                PDR_ADDR_PAIR_DELAY_0: rdata_next = {8'h00, delay0_reg};
                PDR_ADDR_PAIR_DELAY_1: rdata_next = {8'h00, delay1_reg};
                PDR_ADDR_STATUS_COMM:  rdata_next = {23'h000000, link_reg, flags_reg};
                PDR_ADDR_CONFIG_ZERO:  rdata_next = {30'h00000000, gainen_reg, offen_reg};
                PDR_ADDR_CONFIG_ONE:   rdata_next = {26'h0000000, osr_reg, pre_reg, ext_reg};
                PDR_ADDR_CHAN_ACTIVE:  rdata_next = {24'h000000, active_reg};
                default:               rdata_next = 32'h00000000;
            endcase
        end
        // A status read returns flags to 1; an update in the same cycle wins.
        if (acc_rd && paddr_i == PDR_ADDR_STATUS_COMM) begin
            flags_next = 8'hFF;
        end
        flags_next = flags_next & ~upd;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            delay0_reg  <= PDR_RST_PAIR_DELAY;
            delay1_reg  <= PDR_RST_PAIR_DELAY;
            link_reg    <= PDR_RST_LINK_MODE;
            offen_reg   <= 1'b0;
            gainen_reg  <= 1'b0;
            ext_reg     <= PDR_RST_EXT_CLOCK;
            pre_reg     <= PDR_RST_PRESCALE;
            osr_reg     <= PDR_RST_OSR_SEL;
            active_reg  <= PDR_RST_CHAN_ACTIVE;
            flags_reg   <= PDR_RST_READY_FLAGS;
            rdata_reg   <= 32'h00000000;
            restart_reg <= 1'b1;
        end else begin
            delay0_reg  <= delay0_next;
            delay1_reg  <= delay1_next;
            link_reg    <= link_next;
            offen_reg   <= offen_next;
            gainen_reg  <= gainen_next;
            ext_reg     <= ext_next;
            pre_reg     <= pre_next;
            osr_reg     <= osr_next;
            active_reg  <= active_next;
            flags_reg   <= flags_next;
            rdata_reg   <= rdata_next;
            restart_reg <= restart_next;
        end
    end

    assign pready_o  = 1'b1;
    assign prdata_o  = rdata_reg;
    assign pslverr_o = 1'b0;

    // ------------------------------------------------------------------
    // Clock source and correction enables
    // ------------------------------------------------------------------
    assign osc_enable_o         = ~ext_reg;
    assign osc_bypass_o         = ext_reg;
    assign osc_out_pin_o        = 1'b0;
    assign osc_out_pin_oe_o     = ext_reg;
    assign offset_corr_enable_o = offen_reg;
    assign gain_corr_enable_o   = gainen_reg;

    // ------------------------------------------------------------------
    // Decimated clock: STEP_CYCLES system cycles times prescale 1/2/4/8
    // ------------------------------------------------------------------

    // The tick is a one-cycle pulse; the counter restarts from zero on every restart.
    // A prescale write does not restart the counter, so the first period after it may be long.
    // Software is expected to write a delay register afterwards to realign all channels.

    logic [15:0] pre_cnt_reg, pre_cnt_next;
    logic        tick;
    logic [15:0] pre_len;

    assign pre_len = 16'(STEP_CYCLES << pre_reg);
    assign tick    = (pre_cnt_reg == pre_len - 16'h0001);

    always_comb begin
        pre_cnt_next = tick ? 16'h0000 : pre_cnt_reg + 16'h0001;
        if (restart_reg) begin
            pre_cnt_next = 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pre_cnt_reg <= 16'h0000;
        end else begin
            pre_cnt_reg <= pre_cnt_next;
        end
    end

    assign decimated_modulator_clock_o = tick;

    // ------------------------------------------------------------------
    // Output-rate timing in decimated periods
    // ------------------------------------------------------------------

    // The code is stored once for the largest ratio. At smaller ratios the sign bit moves down,
    // and the bits above it are ignored, so the same code stays valid across ratio changes.
    // The result is one bit wider than the code so that every step count fits with its sign.

    // Sign-extend the code from the bit chosen by the ratio.
    function automatic logic signed [12:0] pdr_code(input logic [11:0] c, input logic [2:0] sel);
        logic [3:0]         sb;
        logic signed [12:0] v;
        sb = 4'(sel) + 4'h4;
        v  = 13'sh0000;
        for (int i = 0; i < 12; i++) begin
            if (i < int'(sb)) begin
                v[i] = c[i];
            end else begin
                v[i] = c[sb];
            end
        end
        v[12] = c[sb];
        return v;
    endfunction

    logic [12:0]        oversampling_ratio;
    logic [12:0]        half;
    logic [13:0]        ph_cnt_reg, ph_cnt_next;
    logic [11:0]        code [4];
    logic [13:0]        ev_time [4];
    logic signed [12:0] lag_max;
    logic [7:0]         raw;
    logic [13:0]        lag_time;

    // The shift amount is widened first; a three-bit sum would wrap at the largest ratios.
    assign oversampling_ratio     = 13'(1) << (4'(osr_reg) + 4'(PDR_OSR_MIN_LOG2));
    assign half    = oversampling_ratio >> 1;
    assign code[0] = delay1_reg[PDR_FLD_DELAY_LO +: 12];
    assign code[1] = delay1_reg[PDR_FLD_DELAY_HI +: 12];
    assign code[2] = delay0_reg[PDR_FLD_DELAY_LO +: 12];
    assign code[3] = delay0_reg[PDR_FLD_DELAY_HI +: 12];

    always_comb begin
        lag_max = 13'sh0000;
        raw     = 8'h00;
        for (int p = 0; p < 4; p++) begin
            // Even time = reference half-period plus signed code; range stays in -OVERSAMPLING_RATIO/2..OVERSAMPLING_RATIO/2-1.
            ev_time[p] = 14'(half) + 14'(pdr_code(code[p], osr_reg));
            if (tick && ph_cnt_reg == ev_time[p]) begin
                raw[2 * p] = 1'b1;
            end
            if (tick && ph_cnt_reg == 14'(half)) begin
                raw[2 * p + 1] = 1'b1;
            end
            if (active_reg[2 * p] && pdr_code(code[p], osr_reg) > lag_max) begin
                lag_max = pdr_code(code[p], osr_reg);
            end
        end
        lag_time    = 14'(half) + 14'(lag_max);
        ph_cnt_next = ph_cnt_reg;
        if (tick) begin
            ph_cnt_next = (ph_cnt_reg == 14'(oversampling_ratio) - 14'h0001) ? 14'h0000 : ph_cnt_reg + 14'h0001;
        end
        if (restart_reg) begin
            ph_cnt_next = 14'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ph_cnt_reg <= 14'h0000;
        end else begin
            ph_cnt_reg <= ph_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Ready pin, latching and flag updates
    // ------------------------------------------------------------------

    // Latch pulses and the ready pin are registered, one cycle after the matching tick.
    // A restart in flight suppresses any event that the old counter values would produce.
    // The most lagging time includes the odd reference, so a negative code never moves it early.

    logic lag_evt;
    logic drdy_reg, drdy_next;
    logic [7:0] latch_reg, latch_next;

    assign lag_evt = tick && ph_cnt_reg == lag_time && !restart_reg;

    always_comb begin
        if (link_reg) begin
            latch_next = lag_evt ? active_reg : 8'h00;
            drdy_next  = lag_evt;
        end else begin
            latch_next = restart_reg ? 8'h00 : raw & active_reg;
            drdy_next  = |latch_next[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            latch_reg <= 8'h00;
            drdy_reg  <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            drdy_reg  <= drdy_next;
        end
    end

    assign upd           = latch_reg;
    assign chan_latch_o  = latch_reg;
    assign ready_pin_n_o = ~drdy_reg;

endmodule
`default_nettype wire

// File: pdr_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pdr_checker #(
    parameter int STEP_CYCLES = 2
) (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        osc_enable_o,
    input wire logic        osc_bypass_o,
    input wire logic        osc_out_pin_o,
    input wire logic        osc_out_pin_oe_o,
    input wire logic        offset_corr_enable_o,
    input wire logic        gain_corr_enable_o,
    input wire logic        decimated_modulator_clock_o,
    input wire logic [7:0]  chan_latch_o,
    input wire logic        ready_pin_n_o
);
    import pdr_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic acc_wr;
    assign acc_wr = psel_i && penable_i && pwrite_i;
    sequence s_stat_acc;
        psel_i && penable_i && !pwrite_i && paddr_i == PDR_ADDR_STATUS_COMM && chan_latch_o == 8'h00;
    endsequence
    sequence s_stat_setup;
        psel_i && !penable_i && !pwrite_i && paddr_i == PDR_ADDR_STATUS_COMM && chan_latch_o == 8'h00;
    endsequence
    property p_osc_mode;
        osc_out_pin_oe_o == osc_bypass_o && osc_enable_o == !osc_bypass_o;
    endproperty
    property p_osc_low;
        osc_out_pin_oe_o |-> !osc_out_pin_o;
    endproperty
    property p_ext_write;
        acc_wr && paddr_i == PDR_ADDR_CONFIG_ONE |=> osc_bypass_o == $past(pwdata_i[0]);
    endproperty
    property p_corr_write;
        acc_wr && paddr_i == PDR_ADDR_CONFIG_ZERO |=>
            {gain_corr_enable_o, offset_corr_enable_o} == $past(pwdata_i[1:0]);
    endproperty
    property p_restart;
        acc_wr && (paddr_i == PDR_ADDR_PAIR_DELAY_0 || paddr_i == PDR_ADDR_PAIR_DELAY_1) |->
            ##2 (!chan_latch_o[1])[*6];
    endproperty
    property p_odd_sync;
        |(chan_latch_o & 8'hAA) |-> (chan_latch_o & 8'hAA) == 8'hAA;
    endproperty
    property p_ready_src;
        $fell(ready_pin_n_o) |-> chan_latch_o != 8'h00 || $past(chan_latch_o) != 8'h00;
    endproperty
    property p_dm_gap;
        decimated_modulator_clock_o |=> !decimated_modulator_clock_o;
    endproperty
    property p_flags_clear;
        s_stat_acc ##1 (chan_latch_o == 8'h00) ##1 s_stat_setup |=> prdata_o[7:0] == 8'hFF;
    endproperty
    a_osc_mode: assert property (p_osc_mode) else $error("oscillator outputs disagree");
    a_osc_low: assert property (p_osc_low) else $error("oscillator pin not pulled low");
    a_ext_write: assert property (p_ext_write) else $error("clock select not applied");
    a_corr_write: assert property (p_corr_write) else $error("correction enables wrong");
    a_restart: assert property (p_restart) else $error("latch too soon after restart");
    a_odd_sync: assert property (p_odd_sync) else $error("odd channels not together");
    a_ready_src: assert property (p_ready_src) else $error("ready pulse without latch");
    a_dm_gap: assert property (p_dm_gap) else $error("decimated pulse too long");
    a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared by read");
endmodule
bind pdr_phase_ready pdr_checker #(.STEP_CYCLES(STEP_CYCLES)) pdr_checker_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .osc_enable_o(osc_enable_o),
    .osc_bypass_o(osc_bypass_o), .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe_o(osc_out_pin_oe_o),
    .offset_corr_enable_o(offset_corr_enable_o), .gain_corr_enable_o(gain_corr_enable_o),
    .decimated_modulator_clock_o(decimated_modulator_clock_o), .chan_latch_o(chan_latch_o),
    .ready_pin_n_o(ready_pin_n_o)
);
`default_nettype wire

// File: pdr_host.sv
`timescale 1ns/100ps
`default_nettype none
module pdr_host (
    // Clock
    input  wire logic          clk_i,
    // APB master
    output logic               psel_o,
    output logic               penable_o,
    output pdr_pkg::pdr_apb_req_t req_o,
    input  wire logic [31:0]   prdata_i,
    input  wire logic          pready_i,
    // Interrupt line
    input  wire logic          ready_pin_n_i
);
    import pdr_pkg::*;
    int irq_count;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        req_o = '0;
        irq_count = 0;
    end
    // Ready pulses are counted where the pin has settled.
    always @(negedge clk_i) begin
        if (ready_pin_n_i === 1'b0) begin
            irq_count++;
        end
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        psel_o <= 1'b1;
        req_o <= '{paddr: a, pwrite: wr, pwdata: d};
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        q = prdata_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: test_phase_delay_data_ready_logic.sv
`timescale 1ns/100ps
`default_nettype none
module test_phase_delay_data_ready_logic;
    import pdr_pkg::*;
    localparam int STEP = 2;
    logic         clk_i;
    logic         sys_rst_i;
    logic         psel;
    logic         penable;
    pdr_apb_req_t req;
    logic [31:0]  prdata;
    logic         pready;
    logic [3:0]   osc;
    logic [1:0]   corr;
    logic [7:0]   latch;
    logic         rdy_n;
    logic [31:0]  q;
    int           bad_count;
    int           tests_run;
    int           cyc;
    int           w;
    int           n0;
    int           lat_t [8];
    pdr_phase_ready #(.STEP_CYCLES(STEP)) pdr_phase_ready_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(req.pwrite),
        .paddr_i(req.paddr), .pwdata_i(req.pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(),
        .osc_enable_o(osc[3]), .osc_bypass_o(osc[2]), .osc_out_pin_oe_o(osc[1]), .osc_out_pin_o(osc[0]),
        .offset_corr_enable_o(corr[0]), .gain_corr_enable_o(corr[1]), .decimated_modulator_clock_o(),
        .chan_latch_o(latch), .ready_pin_n_o(rdy_n));
    pdr_host pdr_host_i (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .req_o(req),
        .prdata_i(prdata), .pready_i(pready), .ready_pin_n_i(rdy_n));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        cyc++;
        for (int i = 0; i < 8; i++) begin
            if (latch[i] === 1'b1) begin
                lat_t[i] = cyc;
            end
        end
    end
    function automatic logic [31:0] gap(input int a, input int b);
        return 32'(a - b);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        pdr_host_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        pdr_host_i.xfer(1'b0, a, 32'h00000000, q);
        check(q, e, "read data");
    endtask
    task automatic delay_run(input logic [11:0] code, input int n);
        wr(PDR_ADDR_PAIR_DELAY_1, {20'h00000, code});
        w = cyc;
        n0 = pdr_host_i.irq_count;
        settle(n);
    endtask
    task automatic t_reset();
        rdc(PDR_ADDR_STATUS_COMM, 32'h000001FF);
        rdc(PDR_ADDR_CONFIG_ONE, 32'h00000038);
        rdc(PDR_ADDR_CHAN_ACTIVE, 32'h000000FF);
        rdc(8'h1C, 32'h00000000);
        wr(PDR_ADDR_STATUS_COMM, 32'h00000100);
        rdc(PDR_ADDR_STATUS_COMM, 32'h000001FF);
        $display("test reset done");
    endtask
    task automatic t_unlinked();
        wr(PDR_ADDR_CONFIG_ONE, 32'h00000000);
        wr(PDR_ADDR_STATUS_COMM, 32'h00000000);
        delay_run(12'h003, 50);
        check(gap(lat_t[0], lat_t[1]), 32'(3 * STEP), "lag");
        check(32'(lat_t[1] - w inside {[16 * STEP : 16 * STEP + 5]}), 32'h1, "start");
        check(gap(lat_t[3], lat_t[1]) | gap(lat_t[5], lat_t[1]) | gap(lat_t[7], lat_t[1]), 32'h0, "odd");
        check(32'(pdr_host_i.irq_count - n0), 32'h2, "pulses");
        rdc(PDR_ADDR_STATUS_COMM, 32'h00000000);
        rdc(PDR_ADDR_STATUS_COMM, 32'h000000FF);
        delay_run(12'h01D, 50);
        check(gap(lat_t[1], lat_t[0]), 32'(3 * STEP), "lead");
        delay_run(12'h00F, 80);
        check(gap(lat_t[0], lat_t[1]), 32'(15 * STEP), "top");
        wr(PDR_ADDR_CONFIG_ONE, 32'h00000002);
        delay_run(12'h003, 100);
        check(gap(lat_t[0], lat_t[1]), 32'(6 * STEP), "scaled");
        $display("test unlinked done");
    endtask
    task automatic t_linked();
        wr(PDR_ADDR_CONFIG_ONE, 32'h00000000);
        wr(PDR_ADDR_STATUS_COMM, 32'h00000100);
        delay_run(12'h003, 50);
        check(32'(pdr_host_i.irq_count - n0), 32'h1, "pulses");
        foreach (lat_t[i]) check(gap(lat_t[i], lat_t[0]), 32'h0, "together");
        rdc(PDR_ADDR_STATUS_COMM, 32'h00000100);
        rdc(PDR_ADDR_STATUS_COMM, 32'h000001FF);
        delay_run(12'h01D, 50);
        check(32'(pdr_host_i.irq_count - n0), 32'h1, "pulses");
        check(gap(lat_t[0], lat_t[1]), 32'h0, "together");
        check(32'(lat_t[1] - w inside {[16 * STEP : 16 * STEP + 5]}), 32'h1, "ref");
        $display("test linked done");
    endtask
    task automatic t_clock();
        wr(PDR_ADDR_CONFIG_ONE, 32'h00000001);
        settle(1);
        check(32'(osc), 32'h00000006, "external");
        wr(PDR_ADDR_CONFIG_ONE, 32'h00000000);
        settle(1);
        check(32'(osc), 32'h00000008, "crystal");
        wr(PDR_ADDR_CONFIG_ZERO, 32'h00000003);
        settle(1);
        check(32'(corr), 32'h00000003, "both");
        wr(PDR_ADDR_CONFIG_ZERO, 32'h00000002);
        settle(1);
        check(32'(corr), 32'h00000002, "gain");
        $display("test clock done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_i);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        sys_rst_i = 1'b1;
        bad_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_unlinked();
        t_linked();
        t_clock();
        test_done();
    end
endmodule
`default_nettype wire
